// ---- hdl/srw_map.svh ----
`ifndef SRW_MAP_SVH
`define SRW_MAP_SVH

// timebase
`define SRW_CLK_MHZ 100
`define SRW_CNT_W 32

// reset pulse length, milliseconds
`define SRW_RST_PULSE_MS 200
// watchdog timeout period, milliseconds
`define SRW_WD_PERIOD_MS 1600
// least manual reset low time that counts, nanoseconds
`define SRW_MR_DEB_NS 150

// reset values
`define SRW_RST_OUT_N_INIT 1'b0
`define SRW_WDO_N_INIT 1'b0
`define SRW_PFF_N_INIT 1'b0
`define SRW_MR_STABLE_INIT 1'b1
`define SRW_CNT_INIT 32'h0000_0000

`endif

// ---- hdl/srw_pkg.sv ----
`default_nettype none
`include "srw_map.svh"

package srw_pkg;

	typedef logic [`SRW_CNT_W-1:0] srw_cnt_t;

	typedef enum logic [1:0] {
		SRW_IDLE,
		SRW_ASSERT,
		SRW_STRETCH
	} srw_rst_state_t;

endpackage : srw_pkg

`default_nettype wire

// ---- hdl/srw_wd_if.sv ----
`default_nettype none

interface srw_wd_if;
	logic enable;
	logic hold_clear;
	logic toggle;
	logic expired;

	modport ctrl (
		output enable,
		output hold_clear,
		output toggle,
		input expired
	);

	modport wd (
		input enable,
		input hold_clear,
		input toggle,
		output expired
	);
endinterface : srw_wd_if

`default_nettype wire

// ---- hdl/srw_watchdog.sv ----
`default_nettype none
`include "srw_map.svh"

module srw_watchdog
	import srw_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = `SRW_WD_PERIOD_MS * `SRW_CLK_MHZ * 1000
) (
	input wire logic clock, // system clock
	input wire logic rst_n, // async reset, active low
	srw_wd_if.wd wd // control and timeout status
);

	logic prev_r;
	logic prev_nxt;
	srw_cnt_t cnt_r;
	srw_cnt_t cnt_nxt;
	logic exp_r;
	logic exp_nxt;
	logic clr;

	always_comb begin
		prev_nxt = wd.toggle;
		// either edge restarts timing; reset or a floating input keeps it at zero
		clr = !wd.enable || wd.hold_clear || (wd.toggle != prev_r);
		cnt_nxt = cnt_r;
		exp_nxt = exp_r;
		if (clr) begin
			cnt_nxt = `SRW_CNT_INIT;
			exp_nxt = 1'b0;
		end else if (cnt_r >= srw_cnt_t'(PERIOD_CYC - 1)) begin
			exp_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + srw_cnt_t'(1);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= 1'b0;
			cnt_r <= `SRW_CNT_INIT;
			exp_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign wd.expired = exp_r;

endmodule : srw_watchdog

`default_nettype wire

// ---- hdl/srw_supervisor.sv ----
// Summary of operation
// - system reset asserts once manual reset input has stayed low for the debounce time
// - manual reset input is debounced so switches give a single reset
// - an undriven manual reset input counts as high
// - power-fail flag low while sense is below reference, high otherwise
// - watchdog output goes low after toggle input stays level too long
// - watchdog timeout period is nominally 1.6 seconds
// - any edge of the toggle input clears the watchdog counter
// - watchdog counter held cleared while system reset is asserted
// - undriven toggle input disables the watchdog
// - watchdog output stays low until the counter is next cleared
// - supply-low forces the watchdog output low
// - watchdog output releases at once when supply-low clears
// - each reset trigger gives a 200 ms reset pulse
// - reset stays asserted as long as supply-low is active
// - reset held 200 ms after the later of supply-low or manual clearing
// - watchdog timeout never asserts the system reset by itself
// - active-high reset output is the inverse of the active-low reset without the watchdog, and held low with it
`default_nettype none
`include "srw_map.svh"

module srw_supervisor
	import srw_pkg::*;
#(
	parameter bit HAS_WATCHDOG = 1'b1,
	parameter int unsigned PULSE_CYC = `SRW_RST_PULSE_MS * `SRW_CLK_MHZ * 1000,
	parameter int unsigned WD_CYC = `SRW_WD_PERIOD_MS * `SRW_CLK_MHZ * 1000,
	parameter int unsigned DEB_CYC = (`SRW_MR_DEB_NS * `SRW_CLK_MHZ + 999) / 1000
) (
	input wire logic clock, // 100 MHz timebase
	input wire logic rst_n, // async reset, active low
	input wire logic supply_low, // supply below threshold, active high
	input wire logic manual_reset_n, // manual reset level, active low
	input wire logic manual_reset_drv, // manual reset pin is driven
	input wire logic power_fail_sense, // 1 = sense at or above reference
	input wire logic watchdog_toggle_in, // toggle level from the processor
	input wire logic watchdog_toggle_drv, // toggle pin is driven (not floating)
	output logic sys_reset_n, // system reset, active low
	output logic sys_reset, // system reset, active high variant
	output logic power_fail_flag_n, // power-fail flag, active low
	output logic watchdog_timeout_n // watchdog timeout, active low
);

	srw_wd_if wd_bus ();

	logic mr_level;
	logic mr_stable_r;
	logic mr_stable_nxt;
	srw_cnt_t deb_cnt_r;
	srw_cnt_t deb_cnt_nxt;
	logic trig;
	srw_rst_state_t st_r;
	srw_rst_state_t st_nxt;
	srw_cnt_t pulse_cnt_r;
	srw_cnt_t pulse_cnt_nxt;
	logic rst_out_n_r;
	logic rst_out_n_nxt;
	logic rst_out_r;
	logic rst_out_nxt;
	logic pff_n_r;
	logic pff_n_nxt;
	logic wdo_n_r;
	logic wdo_n_nxt;

	localparam srw_cnt_t DEB_LAST = srw_cnt_t'(DEB_CYC - 1);
	localparam srw_cnt_t PULSE_LAST = srw_cnt_t'(PULSE_CYC - 1);

	// one terminal-count test for both counters, so they end on the same rule
	function automatic logic srw_cnt_done(input srw_cnt_t cnt, input srw_cnt_t last);
		return cnt >= last;
	endfunction : srw_cnt_done

	// manual reset input conditioning
	always_comb begin
		mr_level = !manual_reset_drv || manual_reset_n;
		mr_stable_nxt = mr_stable_r;
		deb_cnt_nxt = `SRW_CNT_INIT;
		// a level must hold for the debounce time before it is taken
		if (mr_level != mr_stable_r) begin
			if (srw_cnt_done(deb_cnt_r, DEB_LAST)) begin
				mr_stable_nxt = mr_level;
			end else begin
				deb_cnt_nxt = deb_cnt_r + srw_cnt_t'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mr_stable_r <= `SRW_MR_STABLE_INIT;
			deb_cnt_r <= `SRW_CNT_INIT;
		end else begin
			mr_stable_r <= mr_stable_nxt;
			deb_cnt_r <= deb_cnt_nxt;
		end
	end

	// reset pulse generator; watchdog expiry is not a trigger here
	always_comb begin
		trig = supply_low || !mr_stable_r;
		st_nxt = st_r;
		pulse_cnt_nxt = pulse_cnt_r;
		case (st_r)
			SRW_IDLE: begin
				if (trig) begin
					st_nxt = SRW_ASSERT;
				end
			end
			SRW_ASSERT: begin
				// held for as long as any trigger stays active
				if (!trig) begin
					st_nxt = SRW_STRETCH;
					pulse_cnt_nxt = `SRW_CNT_INIT;
				end
			end
			SRW_STRETCH: begin
				if (trig) begin
					st_nxt = SRW_ASSERT;
				end else if (srw_cnt_done(pulse_cnt_r, PULSE_LAST)) begin
					st_nxt = SRW_IDLE;
				end else begin
					pulse_cnt_nxt = pulse_cnt_r + srw_cnt_t'(1);
				end
			end
			default: begin
				st_nxt = SRW_ASSERT;
			end
		endcase
	end

	// leaving reset starts a power-on stretch, as after a supply recovery
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SRW_STRETCH;
			pulse_cnt_r <= `SRW_CNT_INIT;
		end else begin
			st_r <= st_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end

	// reset outputs track the next state, so the pins move on the deciding edge
	always_comb begin
		rst_out_n_nxt = (st_nxt == SRW_IDLE);
		rst_out_nxt = 1'b0;
		if (!HAS_WATCHDOG) begin
			rst_out_nxt = !rst_out_n_nxt;
		end
	end

	// without the watchdog the high output starts asserted so the pair stays complementary in reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_out_n_r <= `SRW_RST_OUT_N_INIT;
			rst_out_r <= HAS_WATCHDOG ? 1'b0 : !`SRW_RST_OUT_N_INIT;
		end else begin
			rst_out_n_r <= rst_out_n_nxt;
			rst_out_r <= rst_out_nxt;
		end
	end

	// watchdog hookup; the high-reset variant carries no watchdog at all
	assign wd_bus.hold_clear = !rst_out_n_r;
	assign wd_bus.toggle = watchdog_toggle_in;

	generate
		if (HAS_WATCHDOG) begin : g_wd
			assign wd_bus.enable = watchdog_toggle_drv;
			srw_watchdog #(
				.PERIOD_CYC(WD_CYC)
			) u_watchdog (
				.clock(clock),
				.rst_n(rst_n),
				.wd(wd_bus.wd)
			);
		end else begin : g_no_wd
			assign wd_bus.enable = 1'b0;
			assign wd_bus.expired = 1'b0;
		end
	endgenerate

	// power-fail flag is a one-cycle copy of the comparator decision
	always_comb begin
		pff_n_nxt = power_fail_sense;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pff_n_r <= `SRW_PFF_N_INIT;
		end else begin
			pff_n_r <= pff_n_nxt;
		end
	end

	// low line overrides the counter and releases without waiting for the pulse
	always_comb begin
		wdo_n_nxt = 1'b1;
		if (HAS_WATCHDOG) begin
			wdo_n_nxt = !(supply_low || wd_bus.expired);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wdo_n_r <= `SRW_WDO_N_INIT;
		end else begin
			wdo_n_r <= wdo_n_nxt;
		end
	end

	assign sys_reset_n = rst_out_n_r;
	assign sys_reset = rst_out_r;
	assign power_fail_flag_n = pff_n_r;
	assign watchdog_timeout_n = wdo_n_r;

endmodule : srw_supervisor

`default_nettype wire

// ---- verif/srw_supervisor_properties.sv ----
`default_nettype none
module srw_supervisor_chk #(
	parameter bit HAS_WATCHDOG = 1'b1,
	parameter int unsigned PULSE_CYC = 20
) (
	input wire logic clock, // clk
	input wire logic rst_n, // rst
	input wire logic supply_low, // in
	input wire logic manual_reset_n, // in
	input wire logic manual_reset_drv, // in
	input wire logic power_fail_sense, // in
	input wire logic watchdog_toggle_in, // in
	input wire logic watchdog_toggle_drv, // in
	input wire logic sys_reset_n, // out
	input wire logic sys_reset, // out
	input wire logic power_fail_flag_n, // out
	input wire logic watchdog_timeout_n // out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = PULSE_CYC;
	localparam int PW2 = PULSE_CYC + 2;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// three samples suit a debounce count of three or less
	sequence mr_held_s;
		(manual_reset_drv && !manual_reset_n) [*3];
	endsequence
	supply_rst_a: assert property (supply_low |=> !sys_reset_n) else $error("reset free");
	supply_wdo_a: assert property (HAS_WATCHDOG && supply_low |=> !watchdog_timeout_n)
		else $error("timeout free");
	wdo_free_a: assert property (HAS_WATCHDOG && $fell(supply_low) |=> watchdog_timeout_n)
		else $error("timeout stuck");
	pf_flag_a: assert property (rst_n |=> power_fail_flag_n == $past(power_fail_sense))
		else $error("flag lag");
	manual_rst_a: assert property (mr_held_s |-> ##2 !sys_reset_n) else $error("press lost");
	stretch_end_a: assert property ($fell(supply_low) && manual_reset_n
		|-> ##[PW:PW2] $rose(sys_reset_n)) else $error("stretch length");
	stretch_low_a: assert property ($fell(supply_low) |-> !sys_reset_n [*8])
		else $error("stretch short");
	high_rst_a: assert property (rst_n |=> sys_reset == (HAS_WATCHDOG ? 1'b0 : !sys_reset_n))
		else $error("high reset");
endmodule : srw_supervisor_chk
bind srw_supervisor srw_supervisor_chk #(.HAS_WATCHDOG(HAS_WATCHDOG), .PULSE_CYC(PULSE_CYC))
	i_chk (.*);
`default_nettype wire

// ---- verif/srw_cpu_model.sv ----
`default_nettype none
module srw_cpu_model (
	input wire logic clock, // timebase
	input wire logic run, // keep feeding
	input wire logic flt, // release line
	output logic toggle, // line level
	output logic drv // line driven
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] div_r = 5'h00;
	always_ff @(posedge clock) div_r <= div_r + 5'(run);
	// a released line flips rather than keeping its last level
	assign toggle = div_r[4] ^ flt;
	assign drv = !flt;
endmodule : srw_cpu_model
`default_nettype wire

// ---- verif/srw_supervisor_tb.sv ----
`default_nettype none
module srw_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 20;
	localparam int WD = 50;
	logic clock = 1'b0, rst_n = 1'b0, supply_low = 1'b0, pf_sense = 1'b1;
	logic mr_n = 1'b1, mr_drv = 1'b1, run = 1'b0, flt = 1'b0, tog, tdrv, rn, pff_n, wdo_n;
	logic rh, rn2, rh2, wdo2;
	int err_total = 0, n_compared = 0, n;
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
	$display("BAD %s exp %b got %b", nm, exp, got); end end
	srw_cpu_model i_cpu (.clock, .run, .flt, .toggle(tog), .drv(tdrv));
	srw_supervisor #(.PULSE_CYC(PW), .WD_CYC(WD), .DEB_CYC(2)) i_dut (.clock, .rst_n, .supply_low,
		.manual_reset_n(mr_n), .manual_reset_drv(mr_drv), .power_fail_sense(pf_sense),
		.watchdog_toggle_in(tog), .watchdog_toggle_drv(tdrv), .sys_reset_n(rn), .sys_reset(rh),
		.power_fail_flag_n(pff_n), .watchdog_timeout_n(wdo_n));
	srw_supervisor #(.HAS_WATCHDOG(1'b0), .PULSE_CYC(PW), .WD_CYC(WD), .DEB_CYC(2)) i_dut_hr (
		.clock, .rst_n, .supply_low, .manual_reset_n(mr_n), .manual_reset_drv(mr_drv),
		.power_fail_sense(pf_sense), .watchdog_toggle_in(tog), .watchdog_toggle_drv(tdrv),
		.sys_reset_n(rn2), .sys_reset(rh2), .power_fail_flag_n(), .watchdog_timeout_n(wdo2));
	initial begin
		forever #5 clock = !clock;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc
	task automatic pulse_len;
		for (n = 0; rn !== 1'b1 && n < 99; n++) begin
			cyc(1);
		end
	endtask : pulse_len
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	task automatic t_power;
		`CHK("high in reset", rh2, 1'b1)
		@(posedge clock) rst_n <= 1'b1;
		pulse_len();
		`CHK("pulse", n inside {[PW - 1:PW + 2]}, 1'b1)
		`CHK("high freed", rh2, 1'b0)
		`CHK("high tied", rh, 1'b0)
	endtask : t_power
	task automatic t_watchdog;
		@(posedge clock) run <= 1'b1;
		cyc(3 * WD);
		`CHK("fed", wdo_n, 1'b1)
		@(posedge clock) run <= 1'b0;
		cyc(WD + 40);
		`CHK("starved", wdo_n, 1'b0)
		`CHK("no reset", rn, 1'b1)
		`CHK("no watchdog", wdo2, 1'b1)
		@(posedge clock) run <= 1'b1;
		cyc(20);
		`CHK("refed", wdo_n, 1'b1)
		@(posedge clock) {run, flt} <= 2'b01;
		cyc(3 * WD);
		`CHK("floated", wdo_n, 1'b1)
		@(posedge clock) flt <= 1'b0;
	endtask : t_watchdog
	task automatic t_manual;
		@(posedge clock) mr_n <= 1'b0;
		@(posedge clock) mr_n <= 1'b1;
		cyc(6);
		`CHK("short press", rn, 1'b1)
		@(posedge clock) {mr_drv, mr_n, pf_sense} <= 3'b000;
		cyc(8);
		`CHK("floating", rn, 1'b1)
		`CHK("pf low", pff_n, 1'b0)
		@(posedge clock) mr_drv <= 1'b1;
		cyc(6);
		`CHK("press", rn, 1'b0)
		@(posedge clock) {mr_n, pf_sense} <= 2'b11;
		cyc(PW + 8);
		`CHK("released", rn, 1'b1)
	endtask : t_manual
	task automatic t_supply;
		@(posedge clock) supply_low <= 1'b1;
		cyc(3);
		`CHK("reset", rn, 1'b0)
		`CHK("wdo forced", wdo_n, 1'b0)
		`CHK("high asserted", rh2, 1'b1)
		@(posedge clock) supply_low <= 1'b0;
		cyc(2);
		`CHK("wdo freed", wdo_n, 1'b1)
		pulse_len();
		`CHK("stretch", n inside {[PW - 4:PW]}, 1'b1)
		cyc(WD - 10);
		`CHK("wd held", wdo_n, 1'b1)
	endtask : t_supply
	initial begin
		repeat (2) @(posedge clock);
		t_power();
		t_watchdog();
		t_manual();
		t_supply();
		tally_and_finish();
	end
	// about four times the planned run
	initial begin
		#20us;
		err_total++;
		tally_and_finish();
	end
endmodule : srw_supervisor_tb
`default_nettype wire
